/* File: common/pds_pkg.sv */
package pds_pkg;

  // ************************************************************
  // Widths and settings
  // ************************************************************
  localparam int ADC_W = 12;
  localparam int SHIFT_W = 3;
  localparam logic [SHIFT_W-1:0] SHIFT_NONE = 3'h0;
  localparam logic [SHIFT_W-1:0] SHIFT_MAX = 3'h4;
  localparam int LOW_DROP_8 = 4;
  localparam int FIFO_DEPTH = 8;
  localparam logic [ADC_W-1:0] ADC_ONES = 12'hFFF;

  typedef enum logic {
    PDS_DEPTH_12 = 1'b0,
    PDS_DEPTH_8 = 1'b1
  } pds_depth_e;

  // Setting as latched at frame start
  typedef struct packed {
    pds_depth_e depth;
    logic [SHIFT_W-1:0] shift;
  } pds_cfg_s;

  // One pixel on the stream
  typedef struct packed {
    logic sof;
    logic [ADC_W-1:0] data;
  } pds_pix_s;

endpackage

/* File: src/pds_fifo.sv */
`timescale 1ns/100ps
module pds_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic clk, // Clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [WIDTH-1:0] in_data, // Write word
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  output logic [WIDTH-1:0] out_data, // Head word
  output logic out_valid, // Not empty
  input wire logic out_ready // Drain accepts
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } pds_fifo_s;

  // Empty after reset, so the not-full flag starts high
  localparam pds_fifo_s RST_ST = '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};

  pds_fifo_s st;
  pds_fifo_s next_st;
  logic wr;
  logic rd;

  always_comb begin
    next_st = st;
    wr = in_valid && st.rdy;
    rd = out_ready && (st.cnt != '0);
    if (wr) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
    end
    if (rd) begin
      next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    // Not-full kept as a flop so ready leaves the block straight from a register
    next_st.rdy = (next_st.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = st.rdy;
  assign out_valid = (st.cnt != '0);
  assign out_data = st.mem[st.rp];
endmodule

/* File: src/pds_top.sv */
// Function
// - 12-bit depth with no shift passes converter bits 11..0 unchanged.
// - 12-bit depth shift one outputs bits 10..0 with a zero LSB.
// - 12-bit depth shift two outputs bits 9..0 and two zero LSBs.
// - 12-bit depth shift three outputs bits 8..0 and three zero LSBs.
// - 12-bit depth shift four outputs bits 7..0 and four zero LSBs.
// - 8-bit depth with no shift outputs converter bits 11..4.
// - 8-bit depth shift one outputs converter bits 10..3.
// - 8-bit depth shift two outputs converter bits 9..2.
// - 8-bit depth shift three outputs converter bits 8..1.
// - 8-bit depth shift four outputs converter bits 7..0, a gain of sixteen.
// - Any set converter bit above the window drives all output bits to one.
// - Shift setting zero disables shifting, one to four select the amount.
`timescale 1ns/100ps
module pds_top #(
  parameter int FIFO_DEPTH = pds_pkg::FIFO_DEPTH
) (
  input wire logic clk, // 40 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [pds_pkg::SHIFT_W-1:0] shift_set, // Shift setting 0..4
  input wire logic depth8_set, // 1 selects 8-bit output
  input wire logic [pds_pkg::ADC_W-1:0] adc_data, // Converter sample
  input wire logic adc_sof, // First pixel of frame
  input wire logic adc_valid, // Sample valid
  output logic adc_ready, // Block can take sample
  output logic [pds_pkg::ADC_W-1:0] pix_data, // Output pixel
  output logic pix_sof, // First pixel of frame
  output logic pix_valid, // Output valid
  input wire logic pix_ready, // Downstream accepts
  output logic cfg_err // Setting above four seen at frame start
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    pds_pkg::pds_cfg_s cfg;
    logic err;
    pds_pkg::pds_pix_s opix;
    logic ovalid;
  } pds_top_s;

  pds_top_s st;
  pds_top_s next_st;
  pds_pkg::pds_cfg_s frame_cfg;
  pds_pkg::pds_cfg_s use_cfg;
  pds_pkg::pds_pix_s fin;
  pds_pkg::pds_pix_s fout;
  logic [pds_pkg::ADC_W-1:0] shaped;
  logic f_valid;
  logic f_ready;
  logic take;

  // ************************************************************
  // Frame setting capture
  // ************************************************************
  always_comb begin
    frame_cfg.depth = depth8_set ? pds_pkg::PDS_DEPTH_8 : pds_pkg::PDS_DEPTH_12;
    // out of range means no shift
    frame_cfg.shift = (shift_set > pds_pkg::SHIFT_MAX) ? pds_pkg::SHIFT_NONE : shift_set;
  end

  assign take = adc_valid && f_ready;
  // First pixel of frame uses the fresh setting, no one-pixel lag
  assign use_cfg = (take && adc_sof) ? frame_cfg : st.cfg;

  pds_window u_window (
    .cfg(use_cfg),
    .adc(adc_data),
    .pix(shaped)
  );

  assign fin.sof = adc_sof;
  assign fin.data = shaped;

  // ************************************************************
  // Buffer
  // ************************************************************
  pds_fifo #(
    .WIDTH($bits(pds_pkg::pds_pix_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_data(fin),
    .in_valid(adc_valid),
    .in_ready(f_ready),
    .out_data(fout),
    .out_valid(f_valid),
    .out_ready(!st.ovalid || pix_ready)
  );

  // ************************************************************
  // Output register
  // ************************************************************
  always_comb begin
    next_st = st;
    if (take && adc_sof) begin
      next_st.cfg = frame_cfg;
      next_st.err = shift_set > pds_pkg::SHIFT_MAX;
    end
    if (!st.ovalid || pix_ready) begin
      next_st.ovalid = f_valid;
      if (f_valid) begin
        next_st.opix = fout;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Ready is the FIFO's not-full flag, a register in the FIFO
  assign adc_ready = f_ready;
  assign pix_data = st.opix.data;
  assign pix_sof = st.opix.sof;
  assign pix_valid = st.ovalid;
  assign cfg_err = st.err;
endmodule

/* File: src/pds_window.sv */
`timescale 1ns/100ps
module pds_window (
  input wire pds_pkg::pds_cfg_s cfg, // Latched setting
  input wire logic [pds_pkg::ADC_W-1:0] adc, // Converter sample
  output logic [pds_pkg::ADC_W-1:0] pix // Selected bits, low aligned for 8 bit
);
  logic [2*pds_pkg::ADC_W-1:0] wide;
  logic [pds_pkg::ADC_W-1:0] over_mask;
  logic [pds_pkg::ADC_W-1:0] win;
  logic sat;

  always_comb begin
    wide = {{pds_pkg::ADC_W{1'b0}}, adc} << cfg.shift;
    over_mask = ~(pds_pkg::ADC_ONES >> cfg.shift);
    sat = |(adc & over_mask);
    win = wide[pds_pkg::ADC_W-1:0];
    if (sat) begin
      win = pds_pkg::ADC_ONES;
    end
    if (cfg.depth == pds_pkg::PDS_DEPTH_8) begin
      pix = win >> pds_pkg::LOW_DROP_8;
    end else begin
      pix = win;
    end
  end
endmodule

/* File: tb/pds_adc_model.sv */
`timescale 1ns/100ps
module pds_adc_model (
  input wire logic clk, // Clock
  input wire logic adc_ready, // Block takes
  output logic [11:0] adc_data, // Sample
  output logic adc_sof, // Frame start
  output logic adc_valid // Offered
);
  initial begin
    adc_data = 12'h000;
    adc_sof = 1'b0;
    adc_valid = 1'b0;
  end
  task send(input logic [11:0] d, input logic s);
    adc_data <= d;
    adc_sof <= s;
    adc_valid <= 1'b1;
    @(posedge clk);
    while (!adc_ready) @(posedge clk);
  endtask
  // Idle data toggles so stale values never pass
  task idle();
    adc_valid <= 1'b0;
    adc_data <= ~adc_data;
    adc_sof <= 1'b0;
    @(posedge clk);
  endtask
endmodule

/* File: tb/pds_props.sv */
`timescale 1ns/100ps
module pds_props #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic [2:0] shift_set, // Shift
  input wire logic depth8_set, // Depth
  input wire logic [11:0] adc_data, // Sample
  input wire logic adc_sof, // Frame start
  input wire logic adc_valid, // Offered
  input wire logic adc_ready, // Taken
  input wire logic [11:0] pix_data, // Pixel
  input wire logic pix_sof, // Frame start
  input wire logic pix_valid, // Valid
  input wire logic pix_ready, // Accept
  input wire logic cfg_err // Bad setting
);
  // ****************
  // Stream checks
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic tk, dr;
  logic [4:0] live;
  assign tk = adc_valid && adc_ready;
  assign dr = pix_valid && pix_ready;
  // Words held anywhere inside
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) live <= 5'h00;
    else live <= live + 5'(tk) - 5'(dr);
  a_data_stands: assert property (
    pix_valid && !pix_ready |=> pix_valid && $stable(pix_data)) else $error("pixel moved");
  a_sof_stands: assert property (
    pix_valid && !pix_ready |=> $stable(pix_sof)) else $error("sof moved");
  a_take_answers: assert property (tk |-> ##[2:60] pix_valid) else $error("no pixel");
  a_no_ghost: assert property (pix_valid |-> live != 5'h00) else $error("ghost");
  a_answer_late: assert property (tk && live == 5'h00 |=> !pix_valid) else $error("early");
  a_full_only: assert property (!adc_ready |-> live >= 5'(FIFO_DEPTH)) else $error("refused");
  a_err_sets: assert property (
    tk && adc_sof && shift_set > 3'h4 |=> cfg_err) else $error("err missed");
  a_err_clears: assert property (
    tk && adc_sof && shift_set <= 3'h4 |=> !cfg_err) else $error("err stuck");
  cover property (dr && pix_data == 12'hFFF);
  cover property (!adc_ready);
  cover property (cfg_err);
endmodule
bind pds_top pds_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.*);

/* File: tb/pixel_digital_shift_bench.sv */
`timescale 1ns/100ps
module pixel_digital_shift_bench;
  logic clk = 1'b0, arst_n = 1'b0, depth8_set = 1'b0, pix_ready = 1'b1;
  logic [2:0] shift_set = 3'h0;
  logic [11:0] adc_data, pix_data;
  logic adc_sof, adc_valid, adc_ready, pix_sof, pix_valid, cfg_err;
  int n_mismatch = 0, n_checks = 0;
  logic [12:0] rx_q[$];
  // Pixels are collected as they leave; a pixel that stands one cycle is never missed
  always @(posedge clk) if (pix_valid && pix_ready) rx_q.push_back({pix_sof, pix_data});
  always #12.5 clk = ~clk;
  pds_adc_model adc (.clk(clk), .adc_ready(adc_ready), .adc_data(adc_data),
    .adc_sof(adc_sof), .adc_valid(adc_valid));
  pds_top dut (.clk(clk), .arst_n(arst_n), .shift_set(shift_set), .depth8_set(depth8_set),
    .adc_data(adc_data), .adc_sof(adc_sof), .adc_valid(adc_valid), .adc_ready(adc_ready),
    .pix_data(pix_data), .pix_sof(pix_sof), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .cfg_err(cfg_err));
  task cmp(input logic [11:0] g, input logic [11:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task get(input logic [11:0] e, input logic s);
    int i;
    logic [12:0] w;
    for (i = 0; i < 60 && rx_q.size() == 0; i++) @(posedge clk);
    // No pixel in time leaves unknowns, which the compare counts as a mismatch
    w = 'x;
    if (rx_q.size() != 0) w = rx_q.pop_front();
    cmp(w[11:0], e);
    cmp({11'h000, w[12]}, {11'h000, s});
  endtask
  function logic [11:0] want(input logic d8, input int sh, input logic [11:0] d);
    if ((d >> (12 - sh)) != 0) return d8 ? 12'h0FF : 12'hFFF;
    return d8 ? (d >> (4 - sh)) & 12'h0FF : d << sh;
  endfunction
  task t_modes();
    int dp, sh;
    logic [11:0] lo;
    for (dp = 0; dp < 2; dp++) for (sh = 0; sh < 5; sh++) begin
      depth8_set <= dp[0];
      shift_set <= sh[2:0];
      lo = (12'hFFF >> sh) + 12'h001;
      adc.send(12'hA5A >> sh, 1'b1);
      adc.send(lo, 1'b0);
      adc.idle();
      get(want(dp[0], sh, 12'hA5A >> sh), 1'b1);
      get(want(dp[0], sh, lo), 1'b0);
    end
  endtask
  task t_midframe();
    depth8_set <= 1'b0;
    shift_set <= 3'h4;
    adc.send(12'h00F, 1'b1);
    shift_set <= 3'h0;
    adc.send(12'h00F, 1'b0);
    adc.idle();
    get(12'h0F0, 1'b1);
    get(12'h0F0, 1'b0);
  endtask
  task t_err();
    shift_set <= 3'h5;
    adc.send(12'h123, 1'b1);
    adc.idle();
    get(12'h123, 1'b1);
    cmp({11'h000, cfg_err}, 12'h001);
  endtask
  task t_full();
    int i;
    shift_set <= 3'h0;
    pix_ready <= 1'b0;
    for (i = 0; i < 9; i++) adc.send(12'(i), i == 0);
    adc.idle();
    cmp({11'h000, adc_ready}, 12'h000);
    pix_ready <= 1'b1;
    for (i = 0; i < 9; i++) get(12'(i), i == 0);
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_modes();
    t_midframe();
    t_err();
    t_full();
    conclude();
  end
endmodule
